// ---- verilog/dms_defs.svh ----
/*
 register offsets, field positions, reset values and constants of the debug memory service port
 assumes: included by bare name from modules
*/
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH

// register byte offsets
`define DMS_OFF_CTRL      8'h00
`define DMS_OFF_STAT      8'h04
`define DMS_OFF_SCLR      8'h08
`define DMS_OFF_PTR       8'h0c
`define DMS_OFF_SIZE      8'h10
`define DMS_OFF_DATA      8'h14
`define DMS_OFF_REV       8'h28
`define DMS_OFF_CID       8'hf0
`define DMS_OFF_CIDX      8'hf4
`define DMS_OFF_APID      8'hfc

// control bits
`define DMS_CTRL_EN       0
`define DMS_CTRL_DIS      1
`define DMS_CTRL_CRC      2
`define DMS_CTRL_UPR      3
`define DMS_CTRL_ERASE    4

// status bits
`define DMS_ST_DONE       0
`define DMS_ST_HOLD       1
`define DMS_ST_BUS_ERROR_FLAG       2
`define DMS_ST_FAIL       3
`define DMS_ST_LOCK       4
`define DMS_ST_EN         8
`define DMS_ST_PROT       9
`define DMS_ST_DBGP       10
`define DMS_ST_STATE_LO   24

// reset values and constants
`define DMS_RST_WORD      32'h0000_0000
`define DMS_CRC_POLY      32'hedb8_8320
`define DMS_PROT_PTR      32'h0000_0000
`define DMS_PROT_SIZE     32'h0004_0000
`define DMS_PROT_SEED     32'hffff_ffff
`define DMS_PAGE_MASK     32'h0000_01fc

`endif

// ---- verilog/dms_pkg.sv ----
/*
 types of the debug memory service port
 assumes: dms_defs.svh on the include path
*/
package dms_pkg;

   // operation state field codes
   typedef enum logic [2:0] {
      DMS_IDLE  = 3'b000,
      DMS_ERASE = 3'b001,
      DMS_CRC   = 3'b010,
      DMS_UPR   = 3'b011
   } dms_state_t;

   // access port register request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dms_req_t;

   // system bus read request and answer
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } dms_mreq_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [31:0] rdata;
   } dms_mrsp_t;

endpackage : dms_pkg

// ---- verilog/dms_crc_step.sv ----
/*
 one 32-bit word folded into a reflected crc32, bit serial unrolled
 assumes: purely combinational, used by the service port
*/
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
module dms_crc_step
   import dms_pkg::*;
(
   // running value and new word
   input  wire logic [31:0] crcIn,
   input  wire logic [31:0] word,
   // folded value
   output logic [31:0]      crcOut
);
   logic [31:0] c [0:32];
   assign c[0] = crcIn ^ word;
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         assign c[i+1] = c[i][0] ? ((c[i] >> 1) ^ `DMS_CRC_POLY) : (c[i] >> 1);
      end
   endgenerate
   assign crcOut = c[32];
endmodule : dms_crc_step
`default_nettype wire

// ---- verilog/dms_reg_read.sv ----
/*
 read data multiplexer of the service port, with protection refusals
 assumes: combinational, fed from registers of the core
*/
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
module dms_reg_read
   import dms_pkg::*;
#(
   parameter logic [31:0] REV_VAL  = 32'h0000_0100,
   parameter logic [31:0] CID_VAL  = 32'h1234_5678,
   parameter logic [31:0] CIDX_VAL = 32'h0000_0000,
   parameter logic [31:0] APID_VAL = 32'h0055_0000
)
(
   // request
   input  wire logic [7:0]  addr,
   input  wire logic        prot,
   input  wire logic        busy,
   // sources
   input  wire logic [31:0] statWord,
   input  wire logic [31:0] ptrWord,
   input  wire logic [31:0] sizeWord,
   input  wire logic [31:0] dataWord,
   // result
   output logic [31:0]      rdata,
   output logic             refused
);
   always_comb begin
      rdata   = `DMS_RST_WORD;
      refused = 1'b0;
      unique case (addr)
         `DMS_OFF_STAT: rdata = statWord;
         `DMS_OFF_PTR: begin
            refused = prot && busy;
            rdata   = refused ? `DMS_RST_WORD : ptrWord;
         end
         `DMS_OFF_SIZE: begin
            refused = prot;
            rdata   = prot ? `DMS_RST_WORD : sizeWord;
         end
         `DMS_OFF_DATA: begin
            refused = prot && busy;
            rdata   = refused ? `DMS_RST_WORD : dataWord;
         end
         `DMS_OFF_REV:  rdata = REV_VAL;
         `DMS_OFF_CID:  rdata = CID_VAL;
         `DMS_OFF_CIDX: rdata = CIDX_VAL;
         `DMS_OFF_APID: rdata = APID_VAL;
         default:       rdata = `DMS_RST_WORD;
      endcase
   end
endmodule : dms_reg_read
`default_nettype wire

// ---- verilog/dms_service_port.sv ----
/*
 debug memory service port: chip erase, core reset hold, user page read, crc32 over memory
 assumes: access port requests synchronous to mclk, one per cycle; system bus and flash
 controller answer with one-cycle pulses
*/
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
module dms_service_port
   import dms_pkg::*;
#(
   parameter logic [31:0] REV_VAL  = 32'h0000_0100,
   parameter logic [31:0] CID_VAL  = 32'h1234_5678,
   parameter logic [31:0] CIDX_VAL = 32'h0000_0000,
   parameter logic [31:0] APID_VAL = 32'h0055_0000,
   parameter logic [31:0] UP_BASE  = 32'h0080_0000
)
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   // access port register bus
   input  wire dms_req_t    apReq,
   output logic [31:0]      apRdata,
   output logic             apRvalid,
   // system state
   input  wire logic        protIn,
   input  wire logic        dbgPresent,
   input  wire logic        holdReq,
   input  wire logic        extResetActive,
   // core reset hold to power manager
   output logic             coreHold,
   // erase sequence to memory controllers
   output logic [1:0]       eraseStep,
   output logic             eraseStart,
   input  wire logic        eraseAck,
   input  wire logic        eraseFail,
   output logic             protClear,
   // user page and crc reads over the system bus
   output dms_mreq_t        memReq,
   input  wire dms_mrsp_t   memRsp
);
   dms_state_t  state_reg;
   logic        en_reg;
   logic        done_reg;
   logic        hold_reg;
   logic        bus_error_flag_reg;
   logic        fail_reg;
   logic        lock_reg;
   logic [31:0] ptr_reg;
   logic [31:0] size_reg;
   logic [31:0] data_reg;
   logic        wait_reg;
   logic [31:0] crcNext;
   logic [31:0] rdMux;
   logic        rdRefused;
   logic        wrCtrl;
   logic        wrSclr;
   logic        idle;
   logic        opDone;
   logic        disCmd;
   logic [31:0] statWord;

   assign wrCtrl = ce && apReq.valid && apReq.write && apReq.addr == `DMS_OFF_CTRL;
   assign disCmd = wrCtrl && apReq.wdata[`DMS_CTRL_DIS];
   assign wrSclr = ce && en_reg && apReq.valid && apReq.write && apReq.addr == `DMS_OFF_SCLR;
   assign idle   = state_reg == DMS_IDLE;

   // operation finish pulse
   always_comb begin
      opDone = 1'b0;
      unique case (state_reg)
         DMS_IDLE:  opDone = 1'b0;
         DMS_ERASE: opDone = eraseAck && eraseStep == 2'd2;
         DMS_CRC:   opDone = memRsp.valid && (size_reg <= 32'd4 || memRsp.err);
         DMS_UPR:   opDone = memRsp.valid;
         default:   opDone = 1'b0;
      endcase
   end

   // enable bit, disable wins and clears
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         en_reg <= 1'b0;
      end else if (ce) begin
         if (disCmd)
            en_reg <= 1'b0;
         else if (wrCtrl && apReq.wdata[`DMS_CTRL_EN])
            en_reg <= 1'b1;
      end
   end

   // operation sequencing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= DMS_IDLE;
         wait_reg  <= 1'b0;
         eraseStep <= 2'd0;
      end else if (ce) begin
         if (disCmd) begin
            state_reg <= DMS_IDLE;
            wait_reg  <= 1'b0;
            eraseStep <= 2'd0;
         end else if (idle && en_reg && wrCtrl) begin
            wait_reg <= 1'b0;
            if (apReq.wdata[`DMS_CTRL_ERASE]) begin
               state_reg <= DMS_ERASE;
               eraseStep <= 2'd0;
            end else if (apReq.wdata[`DMS_CTRL_CRC]) begin
               state_reg <= DMS_CRC;
            end else if (apReq.wdata[`DMS_CTRL_UPR]) begin
               state_reg <= DMS_UPR;
            end
         end else if (opDone) begin
            state_reg <= DMS_IDLE;
            wait_reg  <= 1'b0;
            eraseStep <= 2'd0;
         end else if (state_reg == DMS_ERASE) begin
            if (eraseAck) begin
               eraseStep <= eraseStep + 2'd1;
               wait_reg  <= 1'b0;
            end else begin
               wait_reg <= 1'b1;
            end
         end else if (state_reg != DMS_IDLE) begin
            if (memRsp.valid)
               wait_reg <= 1'b0;
            else
               wait_reg <= 1'b1;
         end
      end
   end

   assign eraseStart = state_reg == DMS_ERASE && !wait_reg;
   assign protClear  = state_reg == DMS_ERASE && eraseStep == 2'd2 && eraseAck;

   // bus read issue
   always_comb begin
      memReq = '0;
      if (!wait_reg && (state_reg == DMS_CRC || state_reg == DMS_UPR)) begin
         memReq.valid = 1'b1;
         memReq.addr = state_reg == DMS_UPR ? (UP_BASE | (ptr_reg & `DMS_PAGE_MASK)) : ptr_reg;
      end
   end

   dms_crc_step u_crc (
      .crcIn  (data_reg),
      .word   (memRsp.rdata),
      .crcOut (crcNext)
   );

   // pointer, size and data registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ptr_reg  <= `DMS_RST_WORD;
         size_reg <= `DMS_RST_WORD;
         data_reg <= `DMS_RST_WORD;
      end else if (ce) begin
         if (disCmd) begin
            ptr_reg  <= `DMS_RST_WORD;
            size_reg <= `DMS_RST_WORD;
            data_reg <= `DMS_RST_WORD;
         end else if (idle && en_reg && wrCtrl && protIn && apReq.wdata[`DMS_CTRL_CRC]
                      && !apReq.wdata[`DMS_CTRL_ERASE]) begin
            ptr_reg  <= `DMS_PROT_PTR;
            size_reg <= `DMS_PROT_SIZE;
            data_reg <= `DMS_PROT_SEED;
         end else if (state_reg == DMS_UPR && memRsp.valid) begin
            data_reg <= memRsp.rdata;
            ptr_reg  <= ptr_reg + 32'd4;
         end else if (state_reg == DMS_CRC && memRsp.valid && !memRsp.err) begin
            data_reg <= crcNext;
            ptr_reg  <= ptr_reg + 32'd4;
            size_reg <= size_reg - 32'd4;
         end else if (idle && en_reg && apReq.valid && apReq.write) begin
            if (apReq.addr == `DMS_OFF_PTR)
               ptr_reg <= {apReq.wdata[31:2], 2'b00};
            if (apReq.addr == `DMS_OFF_SIZE && !protIn)
               size_reg <= {apReq.wdata[31:2], 2'b00};
            if (apReq.addr == `DMS_OFF_DATA)
               data_reg <= apReq.wdata;
         end
      end
   end

   // sticky flags, set wins over clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_reg <= 1'b0;
         bus_error_flag_reg <= 1'b0;
         fail_reg <= 1'b0;
         lock_reg <= 1'b0;
      end else if (ce) begin
         if (disCmd) begin
            done_reg <= 1'b0;
            bus_error_flag_reg <= 1'b0;
            fail_reg <= 1'b0;
            lock_reg <= 1'b0;
         end else begin
            if (opDone)
               done_reg <= 1'b1;
            else if (wrSclr && apReq.wdata[`DMS_ST_DONE])
               done_reg <= 1'b0;
            if (state_reg != DMS_IDLE && state_reg != DMS_ERASE && memRsp.valid && memRsp.err)
               bus_error_flag_reg <= 1'b1;
            else if (wrSclr && apReq.wdata[`DMS_ST_BUS_ERROR_FLAG])
               bus_error_flag_reg <= 1'b0;
            if (state_reg == DMS_ERASE && eraseAck && eraseFail)
               fail_reg <= 1'b1;
            else if (wrSclr && apReq.wdata[`DMS_ST_FAIL])
               fail_reg <= 1'b0;
            if (en_reg && protIn && apReq.valid && ce && (rdRefused && !apReq.write
                || apReq.write && apReq.addr == `DMS_OFF_SIZE))
               lock_reg <= 1'b1;
            else if (wrSclr && apReq.wdata[`DMS_ST_LOCK])
               lock_reg <= 1'b0;
         end
      end
   end

   // core reset hold, not cleared by disable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hold_reg <= 1'b0;
      end else if (ce) begin
         if (extResetActive)
            hold_reg <= 1'b0;
         else if (holdReq)
            hold_reg <= 1'b1;
         else if (wrSclr && apReq.wdata[`DMS_ST_HOLD] && !protIn)
            hold_reg <= 1'b0;
      end
   end
   assign coreHold = hold_reg;

   always_comb begin
      statWord = `DMS_RST_WORD;
      statWord[`DMS_ST_DONE] = done_reg;
      statWord[`DMS_ST_HOLD] = hold_reg;
      statWord[`DMS_ST_BUS_ERROR_FLAG] = bus_error_flag_reg;
      statWord[`DMS_ST_FAIL] = fail_reg;
      statWord[`DMS_ST_LOCK] = lock_reg;
      statWord[`DMS_ST_EN]   = en_reg;
      statWord[`DMS_ST_PROT] = protIn;
      statWord[`DMS_ST_DBGP] = dbgPresent;
      statWord[`DMS_ST_STATE_LO +: 3] = state_reg;
   end

   dms_reg_read #(
      .REV_VAL  (REV_VAL),
      .CID_VAL  (CID_VAL),
      .CIDX_VAL (CIDX_VAL),
      .APID_VAL (APID_VAL)
   ) u_read (
      .addr     (apReq.addr),
      .prot     (protIn),
      .busy     (!idle),
      .statWord (statWord),
      .ptrWord  (ptr_reg),
      .sizeWord (size_reg),
      .dataWord (data_reg),
      .rdata    (rdMux),
      .refused  (rdRefused)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         apRdata  <= `DMS_RST_WORD;
         apRvalid <= 1'b0;
      end else if (ce) begin
         apRvalid <= apReq.valid && !apReq.write;
         apRdata  <= (en_reg && apReq.valid && !apReq.write) ? rdMux : `DMS_RST_WORD;
      end
   end
endmodule : dms_service_port
`default_nettype wire

// ---- testbench/dms_checker.sv ----
/*
 port assertions of the debug memory service port
 assumes: bound to dms_service_port, one clock mclk, reset rst
*/
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
module dms_checker
   import dms_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ce,
   // access port
   input wire dms_req_t    apReq,
   input wire logic [31:0] apRdata,
   input wire logic        apRvalid,
   // system state
   input wire logic        protIn,
   input wire logic        dbgPresent,
   input wire logic        holdReq,
   input wire logic        extResetActive,
   input wire logic        coreHold,
   // erase and memory
   input wire logic [1:0]  eraseStep,
   input wire logic        eraseStart,
   input wire logic        eraseAck,
   input wire logic        eraseFail,
   input wire logic        protClear,
   input wire dms_mreq_t   memReq,
   input wire dms_mrsp_t   memRsp
);
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_readAns; ce && apReq.valid && !apReq.write |=> apRvalid; endproperty
   a_readAns: assert property (p_readAns) else $error("read not answered");
   property p_writeQuiet; ce && apReq.valid && apReq.write |=> !apRvalid; endproperty
   a_writeQuiet: assert property (p_writeQuiet) else $error("write answered");
   property p_sizeRefused;
      ce && protIn && apReq.valid && !apReq.write && apReq.addr == `DMS_OFF_SIZE
         |=> apRdata == 32'h0;
   endproperty
   a_sizeRefused: assert property (p_sizeRefused) else $error("size leaked");
   property p_holdSet; ce && holdReq && !extResetActive |=> coreHold; endproperty
   a_holdSet: assert property (p_holdSet) else $error("hold not raised");
   property p_holdPin; ce && extResetActive && !holdReq |=> !coreHold; endproperty
   a_holdPin: assert property (p_holdPin) else $error("hold kept");
   property p_eraseNext;
      ce && eraseAck && !eraseFail && eraseStep != 2'h2
         |=> eraseStart && eraseStep == $past(eraseStep) + 2'h1;
   endproperty
   a_eraseNext: assert property (p_eraseNext) else $error("erase order");
   property p_protClr;
      protClear |-> eraseStep == 2'h2 ##1 !eraseStart && eraseStep == 2'h0;
   endproperty
   a_protClr: assert property (p_protClr) else $error("early unprotect");
   property p_memOne; ce && memReq.valid |=> !memReq.valid; endproperty
   a_memOne: assert property (p_memOne) else $error("fetch held");

   c_erase: cover property (protClear);
   c_hold: cover property ($fell(coreHold));
   c_bus_error_flag: cover property (memRsp.valid && memRsp.err);
endmodule : dms_checker
bind dms_service_port dms_checker dms_checker_i (.mclk(mclk), .rst(rst), .ce(ce),
   .apReq(apReq), .apRdata(apRdata), .apRvalid(apRvalid), .protIn(protIn),
   .dbgPresent(dbgPresent), .holdReq(holdReq), .extResetActive(extResetActive),
   .coreHold(coreHold), .eraseStep(eraseStep), .eraseStart(eraseStart),
   .eraseAck(eraseAck), .eraseFail(eraseFail), .protClear(protClear),
   .memReq(memReq), .memRsp(memRsp));
`default_nettype wire

// ---- testbench/dms_mem_model.sv ----
/*
 system bus and erase controller model answering the service port
 assumes: one-cycle request pulses, answer two or seven cycles after the request
*/
`timescale 1ns/1ps
`default_nettype none
module dms_mem_model
   import dms_pkg::*;
#(
   parameter logic [31:0] ERR_ADDR = 32'h0000_0800
)
(
   // clock and reset
   input  wire logic      mclk,
   input  wire logic      rst,
   input  wire logic      slow,
   // system bus
   input  wire dms_mreq_t memReq,
   output dms_mrsp_t      memRsp,
   // erase controller
   input  wire logic      eraseStart,
   output logic           eraseAck,
   output logic           eraseFail
);
   logic [31:0] addrReg;
   logic [3:0]  memCnt;
   logic [3:0]  erCnt;

   // slow erase phases report a failure
   assign eraseFail = eraseAck && slow;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         memRsp  <= '0;
         memCnt  <= 4'h0;
         addrReg <= 32'h0;
      end else begin
         memRsp.valid <= 1'b0;
         memRsp.err   <= 1'b0;
         memRsp.rdata <= ~memRsp.rdata;
         if (memReq.valid) begin
            addrReg <= memReq.addr;
            memCnt  <= slow ? 4'h6 : 4'h1;
         end else if (memCnt != 4'h0) begin
            memCnt <= memCnt - 4'h1;
         end
         if (memCnt == 4'h1) begin
            memRsp.valid <= 1'b1;
            memRsp.err   <= addrReg == ERR_ADDR;
            memRsp.rdata <= {addrReg[15:0], ~addrReg[15:0]};
         end
      end
   end

   // erase phase completion
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         erCnt    <= 4'h0;
         eraseAck <= 1'b0;
      end else begin
         eraseAck <= erCnt == 4'h1;
         if (eraseStart) begin
            erCnt <= slow ? 4'h6 : 4'h1;
         end else if (erCnt != 4'h0) begin
            erCnt <= erCnt - 4'h1;
         end
      end
   end
endmodule : dms_mem_model
`default_nettype wire

// ---- testbench/tb.sv ----
/*
 testbench of the debug memory service port: register tasks, directed scenarios
 assumes: dms_mem_model on the far side, checker bound to the design
*/
`timescale 1ns/1ps
`default_nettype none
`include "dms_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb
   import dms_pkg::*;
;
   localparam logic [31:0] UPB = 32'h0080_0000;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        protIn = 1'b0;
   logic        holdReq = 1'b0;
   logic        extRst = 1'b0;
   logic        slow = 1'b1;
   dms_req_t    apReq = '0;
   logic [31:0] apRdata;
   logic        apRvalid;
   logic        coreHold;
   logic [1:0]  eraseStep;
   logic        eraseStart;
   logic        eraseAck;
   logic        eraseFail;
   logic        protClear;
   dms_mreq_t   memReq;
   dms_mrsp_t   memRsp;
   logic [31:0] lastAddr;
   int          nClr = 0;
   int          miscompares = 0;
   int          checks_done = 0;

   always #2.5 mclk = ~mclk;
   always @(posedge mclk) if (memReq.valid) lastAddr <= memReq.addr;
   always @(posedge mclk) if (protClear) nClr++;

   dms_service_port #(.UP_BASE(UPB)) dms_service_port_i (.mclk(mclk), .rst(rst),
      .ce(1'b1), .apReq(apReq), .apRdata(apRdata), .apRvalid(apRvalid),
      .protIn(protIn), .dbgPresent(1'b1), .holdReq(holdReq),
      .extResetActive(extRst), .coreHold(coreHold), .eraseStep(eraseStep),
      .eraseStart(eraseStart), .eraseAck(eraseAck), .eraseFail(eraseFail),
      .protClear(protClear), .memReq(memReq), .memRsp(memRsp));
   dms_mem_model dms_mem_model_i (.mclk(mclk), .rst(rst), .slow(slow),
      .memReq(memReq), .memRsp(memRsp), .eraseStart(eraseStart),
      .eraseAck(eraseAck), .eraseFail(eraseFail));

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      apReq <= '{1'b1, 1'b1, a, d};
      @(negedge mclk);
      apReq <= '0;
   endtask : wr
   task automatic rdw(input logic [7:0] a, output logic [31:0] d);
      @(negedge mclk);
      apReq <= '{1'b1, 1'b0, a, 32'h0};
      @(negedge mclk);
      apReq <= '0;
      `CHK(apRvalid, 1'b1)
      d = apRdata;
   endtask : rdw
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rdw(a, d);
      `CHK(d, e)
   endtask : rdc
   task automatic waitDone();
      logic [31:0] s;
      s = 32'h0;
      for (int i = 0; i < 100 && s[0] !== 1'b1; i++) rdw(`DMS_OFF_STAT, s);
      `CHK(s[0], 1'b1)
   endtask : waitDone
   task automatic pulseHold();
      @(negedge mclk) begin
         extRst  <= 1'b1;
         holdReq <= 1'b1;
      end
      @(negedge mclk) extRst <= 1'b0;
      @(negedge mclk) holdReq <= 1'b0;
   endtask : pulseHold
   function automatic logic [31:0] crcw(input logic [31:0] c, input logic [31:0] w);
      c = c ^ w;
      for (int i = 0; i < 32; i++) c = c[0] ? (c >> 1) ^ `DMS_CRC_POLY : c >> 1;
      return c;
   endfunction : crcw
   function automatic logic [31:0] memWord(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction : memWord
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      #100000;
      miscompares++;
      finish_test();
   end

   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst <= 1'b0;
      // disabled, then enabled
      wr(`DMS_OFF_PTR, 32'h0000_0040);
      rdc(`DMS_OFF_STAT, 32'h0);
      wr(`DMS_OFF_CTRL, 32'h1);
      rdc(`DMS_OFF_PTR, 32'h0);
      rdc(`DMS_OFF_STAT, 32'h0000_0500);
      rdc(8'h40, 32'h0);
      // user page reads with pointer wrap
      wr(`DMS_OFF_PTR, 32'h0000_0ffc);
      wr(`DMS_OFF_CTRL, 32'h8);
      wr(`DMS_OFF_CTRL, 32'h4);
      rdc(`DMS_OFF_STAT, 32'h0300_0500);
      waitDone();
      `CHK(lastAddr, UPB | 32'h0000_01fc)
      rdc(`DMS_OFF_DATA, memWord(UPB | 32'h0000_01fc));
      rdc(`DMS_OFF_PTR, 32'h0000_1000);
      wr(`DMS_OFF_SCLR, 32'h0);
      rdc(`DMS_OFF_STAT, 32'h0000_0501);
      wr(`DMS_OFF_SCLR, 32'h1);
      rdc(`DMS_OFF_STAT, 32'h0000_0500);
      wr(`DMS_OFF_CTRL, 32'h8);
      waitDone();
      `CHK(lastAddr, UPB)
      // checksum of two words
      wr(`DMS_OFF_SCLR, 32'h1f);
      wr(`DMS_OFF_PTR, 32'h0000_0100);
      wr(`DMS_OFF_SIZE, 32'h8);
      wr(`DMS_OFF_DATA, 32'hffff_ffff);
      wr(`DMS_OFF_CTRL, 32'h4);
      wr(`DMS_OFF_PTR, 32'h0000_0200);
      rdc(`DMS_OFF_STAT, 32'h0200_0500);
      waitDone();
      rdc(`DMS_OFF_DATA, crcw(crcw(32'hffff_ffff, memWord(32'h100)), memWord(32'h104)));
      rdc(`DMS_OFF_STAT, 32'h0000_0501);
      // bus error word
      wr(`DMS_OFF_SCLR, 32'h1);
      wr(`DMS_OFF_PTR, 32'h0000_0800);
      wr(`DMS_OFF_SIZE, 32'h4);
      wr(`DMS_OFF_CTRL, 32'h4);
      waitDone();
      rdc(`DMS_OFF_STAT, 32'h0000_0505);
      // chip erase, prompt answers
      wr(`DMS_OFF_SCLR, 32'h1f);
      slow <= 1'b0;
      wr(`DMS_OFF_CTRL, 32'h10);
      rdc(`DMS_OFF_STAT, 32'h0100_0500);
      waitDone();
      `CHK(nClr, 1)
      // core reset hold
      pulseHold();
      `CHK(coreHold, 1'b1)
      wr(`DMS_OFF_SCLR, 32'h2);
      `CHK(coreHold, 1'b0)
      pulseHold();
      @(negedge mclk) extRst <= 1'b1;
      @(negedge mclk) extRst <= 1'b0;
      `CHK(coreHold, 1'b0)
      // protected chip, aborted checksum
      pulseHold();
      protIn <= 1'b1;
      slow <= 1'b1;
      wr(`DMS_OFF_SCLR, 32'h2);
      `CHK(coreHold, 1'b1)
      rdc(`DMS_OFF_SIZE, 32'h0);
      rdc(`DMS_OFF_STAT, 32'h0000_0713);
      wr(`DMS_OFF_PTR, 32'h0000_0100);
      wr(`DMS_OFF_CTRL, 32'h4);
      rdc(`DMS_OFF_PTR, 32'h0);
      `CHK(lastAddr, `DMS_PROT_PTR)
      wr(`DMS_OFF_CTRL, 32'h2);
      rdc(`DMS_OFF_STAT, 32'h0);
      wr(`DMS_OFF_SCLR, 32'h2);
      `CHK(coreHold, 1'b1)
      protIn <= 1'b0;
      wr(`DMS_OFF_CTRL, 32'h1);
      rdc(`DMS_OFF_PTR, 32'h0);
      rdc(`DMS_OFF_STAT, 32'h0000_0502);
      // failing erase, slow answers
      wr(`DMS_OFF_CTRL, 32'h10);
      waitDone();
      `CHK(nClr, 2)
      rdc(`DMS_OFF_STAT, 32'h0000_050b);
      finish_test();
   end
endmodule : tb
`default_nettype wire
